/* File: rtl/rsc_pkg.sv */
package rsc_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] CAUSE_OFS = 4'h0;
    // cause register field positions
    localparam int TRAP_BIT = 15;
    localparam int ILLOP_BIT = 14;
    localparam int CFGMIS_BIT = 9;
    localparam int BIAS_BIT = 8;
    localparam int PIN_BIT = 7;
    localparam int SWRST_BIT = 6;
    localparam int WDTEN_BIT = 5;
    localparam int WATCHDOG_TIMEOUT_FLAG_BIT = 4;
    localparam int SLEEP_BIT = 3;
    localparam int IDLE_BIT = 2;
    localparam int BOR_BIT = 1;
    localparam int POR_BIT = 0;
    localparam logic [15:0] CAUSE_POR_VAL = 16'h0003;
    localparam logic [15:0] CAUSE_WMASK = 16'hC3FF;
    // timing
    localparam int CLOCK_HZ = 20000000;
    localparam int POWER_UP_TIMER_MS = 64;
    localparam int POR_DELAY_US = 10;
    localparam int POWER_UP_TIMER_CYCLES = POWER_UP_TIMER_MS * (CLOCK_HZ / 1000);
    localparam int POR_CYCLES = POR_DELAY_US * (CLOCK_HZ / 1000000);
    localparam int CNT_W = 21;
    typedef enum logic [1:0] {
        RSC_POR_WAIT = 2'b00,
        RSC_POWER_UP_TIMER_WAIT = 2'b01,
        RSC_RUN = 2'b10,
        RSC_BROWN = 2'b11
    } rsc_state_t;
endpackage : rsc_pkg

/* File: rtl/rsc_top.sv */
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - any of nine sources asserts system reset
// - each reset type sets a flag; illegal op and W share bit 14
// - power-on clears flags, sets bits 1:0
// - software sets/clears flags, never causes reset
// - bit 15 set by trap conflict
// - bit 14 set by illegal op or W
// - bit 9 set by configuration mismatch
// - bit 8 keeps flash bias in sleep
// - bit 7 set by master clear pin
// - bit 6 set by reset instruction
// - bit 5 enables watchdog; fuse overrides
// - bit 4 watchdog timeout; power-save clears
// - bits 3,2 record sleep and idle entry
// - bits 1,0 brown-out and power-on flags
// - defined-reset registers forced, others untouched
// - release only after power-on and timer delays
module rsc_top #(
    parameter int POWER_UP_TIMER_CYC = rsc_pkg::POWER_UP_TIMER_CYCLES,
    parameter int POR_CYC = rsc_pkg::POR_CYCLES
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic master_clear_pin_n,
    input wire logic brownout_detect,
    input wire logic reset_instruction,
    input wire logic watchdog_timeout,
    input wire logic config_mismatch,
    input wire logic trap_conflict,
    input wire logic illegal_opcode,
    input wire logic uninit_w_access,
    input wire logic power_save_sleep,
    input wire logic power_save_idle,
    input wire logic watchdog_fuse_enable,
    input wire logic [rsc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [rsc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [rsc_pkg::DATA_W-1:0] reg_rdata,
    output logic system_reset_out,
    output logic watchdog_enable,
    output logic flash_bias_keep,
    output logic regulator_standby_sleep
);
    import rsc_pkg::*;

    // sampled-level filter: accept a change once stages 2 and 3 agree
    function automatic logic filt(input logic a, input logic b,
                                  input logic old);
        filt = (a == b) ? a : old;
    endfunction : filt

    // register decode shared by the write and read paths
    function automatic logic cause_hit(input logic [ADDR_W-1:0] a);
        cause_hit = (a == CAUSE_OFS);
    endfunction : cause_hit

    logic [2:0] pin_sync;
    logic [2:0] bor_sync;
    logic pin_level;
    logic bor_level;
    logic [15:0] cause;
    logic [15:0] next_cause;
    logic [15:0] set_vec;
    rsc_state_t state;
    logic [CNT_W-1:0] cnt;
    logic any_src;
    logic cause_wr;
    logic cause_rd;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pin_sync <= 3'h0;
            bor_sync <= 3'h0;
            pin_level <= 1'b0;
            bor_level <= 1'b0;
        end else begin
            pin_sync <= {pin_sync[1:0], ~master_clear_pin_n};
            bor_sync <= {bor_sync[1:0], brownout_detect};
            pin_level <= filt(pin_sync[1], pin_sync[2], pin_level);
            bor_level <= filt(bor_sync[1], bor_sync[2], bor_level);
        end
    end

    // immediate sources; power-on is nrst, brown-out held by sequencer
    assign any_src = pin_level | reset_instruction | watchdog_timeout
        | config_mismatch | trap_conflict | illegal_opcode
        | uninit_w_access | bor_level;

    // power-up sequencing
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= RSC_POR_WAIT;
            cnt <= '0;
        end else begin
            case (state)
                RSC_POR_WAIT: begin
                    if (cnt == CNT_W'(POR_CYC - 1)) begin
                        state <= RSC_POWER_UP_TIMER_WAIT;
                        cnt <= '0;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                RSC_POWER_UP_TIMER_WAIT: begin
                    if (bor_level) begin
                        state <= RSC_BROWN;
                        cnt <= '0;
                    end else if (cnt == CNT_W'(POWER_UP_TIMER_CYC - 1)) begin
                        state <= RSC_RUN;
                        cnt <= '0;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                RSC_RUN: begin
                    if (bor_level) begin
                        state <= RSC_BROWN;
                    end
                end
                default: begin
                    if (!bor_level) begin
                        state <= RSC_POWER_UP_TIMER_WAIT;
                        cnt <= '0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            system_reset_out <= 1'b1;
        end else begin
            system_reset_out <= (state != RSC_RUN) | any_src;
        end
    end

    // hardware set events
    always_comb begin
        set_vec = 16'h0000;
        set_vec[TRAP_BIT] = trap_conflict;
        set_vec[ILLOP_BIT] = illegal_opcode | uninit_w_access;
        set_vec[CFGMIS_BIT] = config_mismatch;
        set_vec[PIN_BIT] = pin_level;
        set_vec[SWRST_BIT] = reset_instruction;
        set_vec[WATCHDOG_TIMEOUT_FLAG_BIT] = watchdog_timeout;
        set_vec[SLEEP_BIT] = power_save_sleep;
        set_vec[IDLE_BIT] = power_save_idle;
        set_vec[BOR_BIT] = bor_level;
    end

    assign cause_wr = reg_wr && cause_hit(reg_addr);
    assign cause_rd = reg_rd && cause_hit(reg_addr);

    // write first, then hardware clear, then hardware set wins
    always_comb begin
        next_cause = cause;
        if (cause_wr) begin
            next_cause = reg_wdata & CAUSE_WMASK;
        end
        if (power_save_sleep || power_save_idle) begin
            next_cause[WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b0;
        end
        next_cause = next_cause | set_vec;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cause <= CAUSE_POR_VAL;
        end else begin
            cause <= next_cause;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 16'h0000;
        end else if (cause_rd) begin
            reg_rdata <= cause;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            watchdog_enable <= 1'b0;
            flash_bias_keep <= 1'b0;
            regulator_standby_sleep <= 1'b1;
        end else begin
            watchdog_enable <= watchdog_fuse_enable
                | cause[WDTEN_BIT];
            flash_bias_keep <= cause[BIAS_BIT];
            regulator_standby_sleep <= ~cause[BIAS_BIT];
        end
    end

    a_src_asserts_reset: assert property (
        @(posedge clock) disable iff (!nrst)
        (trap_conflict || illegal_opcode || reset_instruction)
            |=> system_reset_out)
        else $error("reset source did not assert system reset");

    a_sw_no_reset: assert property (
        @(posedge clock) disable iff (!nrst)
        (state == RSC_RUN && !any_src) |=> !system_reset_out)
        else $error("reset asserted without a source");

    a_trap_flag_set: assert property (
        @(posedge clock) disable iff (!nrst)
        trap_conflict |=> cause[TRAP_BIT])
        else $error("trap flag not set");

    a_illegal_flag_set: assert property (
        @(posedge clock) disable iff (!nrst)
        (illegal_opcode || uninit_w_access) |=> cause[ILLOP_BIT])
        else $error("illegal op flag not set");

    a_cfg_flag_set: assert property (
        @(posedge clock) disable iff (!nrst)
        config_mismatch |=> cause[CFGMIS_BIT])
        else $error("config mismatch flag not set");

    a_bias_follows: assert property (
        @(posedge clock) disable iff (!nrst)
        ##1 (flash_bias_keep == $past(cause[BIAS_BIT]))
            && (regulator_standby_sleep == !flash_bias_keep))
        else $error("bias control does not follow bit 8");

    a_wdt_fuse_hold: assert property (
        @(posedge clock) disable iff (!nrst)
        (nrst && watchdog_fuse_enable) |=> watchdog_enable)
        else $error("watchdog disabled while fuse set");

    a_watchdog_timeout_flag_clear: assert property (
        @(posedge clock) disable iff (!nrst)
        (power_save_sleep && !watchdog_timeout) |=> !cause[WATCHDOG_TIMEOUT_FLAG_BIT])
        else $error("watchdog flag not cleared by power save");

    a_unimpl_zero: assert property (
        @(posedge clock) disable iff (!nrst)
        cause[13:10] == 4'h0)
        else $error("unimplemented bits nonzero");

    a_power_up_timer_holds: assert property (
        @(posedge clock) disable iff (!nrst)
        (state != RSC_RUN) |=> system_reset_out)
        else $error("reset released before delays expired");

    a_any_src_reset: assert property (
        @(posedge clock) disable iff (!nrst)
        any_src |=> system_reset_out)
        else $error("active source left system reset low");

    a_pin_flag_set: assert property (
        @(posedge clock) disable iff (!nrst)
        pin_level |=> cause[PIN_BIT])
        else $error("pin reset flag not set");

    a_swr_flag_set: assert property (
        @(posedge clock) disable iff (!nrst)
        reset_instruction |=> cause[SWRST_BIT])
        else $error("reset instruction flag not set");

    a_watchdog_timeout_flag_flag_set: assert property (
        @(posedge clock) disable iff (!nrst)
        watchdog_timeout |=> cause[WATCHDOG_TIMEOUT_FLAG_BIT])
        else $error("watchdog timeout flag not set");

    a_sleep_flag_set: assert property (
        @(posedge clock) disable iff (!nrst)
        power_save_sleep |=> cause[SLEEP_BIT])
        else $error("sleep flag not set");

    a_idle_flag_set: assert property (
        @(posedge clock) disable iff (!nrst)
        power_save_idle |=> cause[IDLE_BIT])
        else $error("idle flag not set");

    a_bor_flag_set: assert property (
        @(posedge clock) disable iff (!nrst)
        bor_level |=> cause[BOR_BIT])
        else $error("brown-out flag not set");

    a_flags_sticky: assert property (
        @(posedge clock) disable iff (!nrst)
        (!cause_wr && !power_save_sleep && !power_save_idle)
            |=> (($past(cause) & ~cause) == 16'h0000))
        else $error("hardware cleared a flag");

    a_set_beats_write: assert property (
        @(posedge clock) disable iff (!nrst)
        (cause_wr && (set_vec != 16'h0000))
            |=> ((cause & $past(set_vec)) == $past(set_vec)))
        else $error("software write beat a hardware set");

    a_rdata_value: assert property (
        @(posedge clock) disable iff (!nrst)
        cause_rd |=> (reg_rdata == $past(cause)))
        else $error("read data does not match cause register");

    a_rdata_idle: assert property (
        @(posedge clock) disable iff (!nrst)
        !cause_rd |=> (reg_rdata == 16'h0000))
        else $error("read data nonzero without a read");

    a_brown_restart: assert property (
        @(posedge clock) disable iff (!nrst)
        (state == RSC_BROWN && !bor_level)
            |=> (state == RSC_POWER_UP_TIMER_WAIT && cnt == '0))
        else $error("brown-out end did not restart the timer");
endmodule : rsc_top

/* File: verif/rsc_src_model.sv */
`timescale 1ns/1ps
// far side: one reset or power-save source held for len cycles
module rsc_src_model (
    input wire logic clock,
    input wire logic fire,
    input wire logic [3:0] sel,
    input wire logic [7:0] len,
    output logic [9:0] src
);
    logic [7:0] cnt = 8'h00;
    logic [3:0] cur = 4'h0;
    always_ff @(posedge clock) begin
        if (fire) begin
            cnt <= len;
            cur <= sel;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end
    end
    // bit 0 is the pin, shown active high here
    assign src = (cnt != 8'h00) ? (10'h001 << cur) : 10'h000;
endmodule : rsc_src_model

/* File: verif/rsc_top_tb.sv */
`timescale 1ns/1ps
module rsc_top_tb;
    import rsc_pkg::*;
    localparam int T_POWER_UP_TIMER = 20;
    localparam int T_POR = 4;
    localparam logic [15:0] T_REL = 16'(T_POR + T_POWER_UP_TIMER + 1);
    logic clock = 0, nrst = 0, fuse = 0, wr = 0, rd = 0, fire = 0;
    logic [3:0] addr = 4'h0, sel = 4'h0;
    logic [7:0] len = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [9:0] src;
    logic rst_out, wdt_en, bias, stby;
    int bad_count = 0, num_checks = 0, cnt;
    logic [15:0] exp_tab [10] = '{16'h0080, 16'h0002, 16'h0040, 16'h0010,
        16'h0200, 16'h8000, 16'h4000, 16'h4000, 16'h0008, 16'h0004};
    initial forever #25 clock = ~clock;
    rsc_src_model i_src (.clock(clock), .fire(fire), .sel(sel), .len(len),
        .src(src));
    rsc_top #(.POWER_UP_TIMER_CYC(T_POWER_UP_TIMER), .POR_CYC(T_POR)) i_dut (.clock(clock),
        .nrst(nrst), .master_clear_pin_n(~src[0]),
        .brownout_detect(src[1]),
        .reset_instruction(src[2]), .watchdog_timeout(src[3]),
        .config_mismatch(src[4]), .trap_conflict(src[5]),
        .illegal_opcode(src[6]), .uninit_w_access(src[7]),
        .power_save_sleep(src[8]), .power_save_idle(src[9]),
        .watchdog_fuse_enable(fuse), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
        .system_reset_out(rst_out), .watchdog_enable(wdt_en),
        .flash_bias_keep(bias), .regulator_standby_sleep(stby));
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    task automatic check(input string nm, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1 check("cause read", rdata, e);
    endtask : rd_reg
    // bounded wait for the master reset level, counting cycles
    task automatic wait_rst(input logic lvl, input int lim);
        cnt = 0;
        while (rst_out !== lvl) begin
            @(posedge clock);
            #1 cnt++;
            if (cnt > lim) begin
                bad_count++;
                close_out();
            end
        end
    endtask : wait_rst
    task automatic power_on;
        nrst <= 1'b0;
        repeat (9) @(posedge clock);
        #1 check("reset held", {15'h0, rst_out}, 16'h0001);
        @(posedge clock);
        nrst <= 1'b1;
        wait_rst(1'b0, 100);
        check("release delay", cnt[15:0], T_REL);
        rd_reg(4'h0, CAUSE_POR_VAL);
    endtask : power_on
    task automatic each_source;
        for (int i = 0; i < 10; i++) begin
            wr_reg(4'h0, (i == 8) ? 16'h0010 : 16'h0000);
            @(posedge clock);
            fire <= 1'b1;
            sel <= i[3:0];
            len <= (i < 2) ? 8'h06 : 8'h02;
            @(posedge clock);
            fire <= 1'b0;
            if (i < 8) begin
                wait_rst(1'b1, 10);
                wait_rst(1'b0, 60);
            end else begin
                repeat (4) @(posedge clock);
                #1 check("no reset", {15'h0, rst_out}, 16'h0000);
            end
            rd_reg(4'h0, exp_tab[i]);
        end
    endtask : each_source
    task automatic soft_bits;
        wr_reg(4'h0, 16'hFFFF);
        rd_reg(4'h0, CAUSE_WMASK);
        @(posedge clock);
        #1 check("sw no reset", {15'h0, rst_out}, 16'h0000);
        check("outs", {13'h0, wdt_en, bias, stby}, 16'h0006);
        wr_reg(4'h0, 16'h0000);
        repeat (2) @(posedge clock);
        #1 check("outs", {13'h0, wdt_en, bias, stby}, 16'h0001);
        @(posedge clock);
        fuse <= 1'b1;
        repeat (2) @(posedge clock);
        #1 check("fuse", {15'h0, wdt_en}, 16'h0001);
        wr_reg(4'h1, 16'hFFFF);
        rd_reg(4'h1, 16'h0000);
        rd_reg(4'h0, 16'h0000);
        // trap pulse overlaps a clearing write: the set must survive
        @(posedge clock);
        fire <= 1'b1;
        sel <= 4'h5;
        len <= 8'h02;
        @(posedge clock);
        fire <= 1'b0;
        wr_reg(4'h0, 16'h0000);
        rd_reg(4'h0, 16'h8000);
        wr_reg(4'h0, 16'hC3FF);
        power_on();
    endtask : soft_bits
    initial begin
        power_on();
        each_source();
        soft_bits();
        close_out();
    end
endmodule : rsc_top_tb
